// ### logic/ccs_pkg.sv
// package: constants, register map and types of the card status and interrupt block
// ****************************************************************
// ****************************************************************
package ccs_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h00;
  localparam logic [7:0] OFS_SECONDARY_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h08;
  localparam logic [7:0] OFS_BLOCK_LENGTH   = 8'h0C;
  localparam logic [7:0] OFS_BLOCK_COUNT    = 8'h10;
  localparam logic [7:0] OFS_BLOCKS_REMAIN  = 8'h14;
  localparam logic [7:0] OFS_FIFO_CONTROL   = 8'h18;
  localparam logic [7:0] OFS_TX_DATA        = 8'h1C;
  localparam logic [7:0] OFS_RX_DATA        = 8'h20;
  localparam logic [7:0] OFS_XFER_CONTROL   = 8'h24;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FLD_FIFO_LEVEL_SEL = 0;
  localparam int FLD_FIFO_DIR_WRITE = 1;
  localparam int FLD_XFER_START     = 0;
  localparam int FLD_TX_SHIFT_EMPTY = 0;
  localparam int FLD_RX_SHIFT_FULL  = 1;
  localparam int FLD_CLOCK_STOPPED  = 2;
  localparam int FLD_XFER_ACTIVE    = 3;
  localparam int FLD_CARD_BUSY      = 4;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int NUM_FLAGS = 13;
  localparam int BLEN_W    = 12;
  localparam int NBLK_W    = 16;
  localparam int LVL_W     = 8;
  localparam logic [NUM_FLAGS-1:0] RST_IRQ_MASK   = 13'h0000;
  localparam logic [BLEN_W-1:0]    RST_BLOCK_LEN  = 12'h200;
  localparam logic [NBLK_W-1:0]    RST_BLOCK_CNT  = 16'h0000;
  localparam logic [1:0]           RST_FIFO_CTRL  = 2'h0;

  // threshold bytes per fifo level select value
  localparam logic [LVL_W-1:0] THRESH_SMALL = 8'h20;
  localparam logic [LVL_W-1:0] THRESH_LARGE = 8'h40;

  // ****************************************************************
  // timing: card clock counts as stopped after this much quiet
  // ****************************************************************
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int CLK_STOP_NS     = 160;
  localparam int CLK_STOP_CYCLES = (CLK_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic transfer_done;
    logic dat3_edge;
    logic rx_ready;
    logic tx_ready;
    logic rsvd8;
    logic response_crc_error;
    logic read_crc_error;
    logic write_crc_error;
    logic response_timeout;
    logic read_data_timeout;
    logic response_done;
    logic busy_done;
    logic data_done;
  } ccs_flags_s;

  // one-cycle strobes from the command and data engines
  typedef struct packed {
    logic cmd_sent;
    logic resp_expected;
    logic resp_received;
    logic resp_crc_err;
    logic resp_timeout;
    logic rd_timeout;
    logic rd_crc_err;
    logic wr_crc_err;
    logic rd_byte_recv;
    logic rd_block_crc_ok;
    logic tx_byte_load;
    logic wr_block_finished;
  } ccs_evt_s;

  typedef enum logic [1:0] {
    XS_IDLE,
    XS_MOVE,
    XS_FINISH
  } ccs_xfer_e;

endpackage : ccs_pkg

// ### logic/ccs_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module ccs_sync
  import ccs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);

  logic meta_r;
  logic sync_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb
  begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;

endmodule : ccs_sync
`default_nettype wire

// ### logic/ccs_status_irq.sv
// status flags, interrupt and dma event logic of the card controller
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ccs_status_irq
  import ccs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire ccs_evt_s          evt,
  input  wire logic              busy_expected,
  input  wire logic              card_busy,
  input  wire logic              tx_shift_empty,
  input  wire logic              rx_shift_full,
  input  wire logic [LVL_W-1:0]  fifo_level,
  input  wire logic [31:0]       rx_fifo_data,
  input  wire logic              card_clock_pin,
  input  wire logic              card_data3_pin,
  output logic                   irq,
  output logic                   dma_rx_req,
  output logic                   dma_tx_req,
  output logic                   tx_fifo_push,
  output logic      [31:0]       tx_fifo_data,
  output logic                   rx_fifo_pop,
  output logic                   xfer_dir_write
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic clk_pin_s;
  logic dat3_pin_s;

  ccs_sync u_sync_clk (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (card_clock_pin),
    .dout  (clk_pin_s)
  );

  ccs_sync u_sync_dat3 (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (card_data3_pin),
    .dout  (dat3_pin_s)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic [31:0] bmask;

  assign take    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_take = take & wb_we_i;
  assign rd_take = take & ~wb_we_i;
  assign bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction : merge

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [NUM_FLAGS-1:0] mask_r;
  logic [NUM_FLAGS-1:0] mask_nxt;
  logic [BLEN_W-1:0]    blen_r;
  logic [BLEN_W-1:0]    blen_nxt;
  logic [NBLK_W-1:0]    nblk_r;
  logic [NBLK_W-1:0]    nblk_nxt;
  logic [1:0]           fctl_r;
  logic [1:0]           fctl_nxt;
  logic [31:0]          m_mask;
  logic [31:0]          m_blen;
  logic [31:0]          m_nblk;
  logic [31:0]          m_fctl;
  logic                 start;

  always_comb
  begin
    m_mask   = merge({{(32-NUM_FLAGS){1'b0}}, mask_r}, bmask, wb_dat_i);
    m_blen   = merge({{(32-BLEN_W){1'b0}}, blen_r}, bmask, wb_dat_i);
    m_nblk   = merge({{(32-NBLK_W){1'b0}}, nblk_r}, bmask, wb_dat_i);
    m_fctl   = merge({30'h0, fctl_r}, bmask, wb_dat_i);
    mask_nxt = mask_r;
    blen_nxt = blen_r;
    nblk_nxt = nblk_r;
    fctl_nxt = fctl_r;
    start    = 1'b0;
    if (wr_take)
    begin
      case (wb_adr_i)
        OFS_IRQ_MASK:     mask_nxt = m_mask[NUM_FLAGS-1:0];
        OFS_BLOCK_LENGTH: blen_nxt = m_blen[BLEN_W-1:0];
        OFS_BLOCK_COUNT:  nblk_nxt = m_nblk[NBLK_W-1:0];
        OFS_FIFO_CONTROL: fctl_nxt = m_fctl[1:0];
        OFS_XFER_CONTROL: start    = wb_sel_i[0] & wb_dat_i[FLD_XFER_START];
        default:          start    = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_r <= RST_IRQ_MASK;
      blen_r <= RST_BLOCK_LEN;
      nblk_r <= RST_BLOCK_CNT;
      fctl_r <= RST_FIFO_CTRL;
    end
    else
    begin
      mask_r <= mask_nxt;
      blen_r <= blen_nxt;
      nblk_r <= nblk_nxt;
      fctl_r <= fctl_nxt;
    end
  end

  assign xfer_dir_write = fctl_r[FLD_FIFO_DIR_WRITE];

  // ****************************************************************
  // transfer tracking: byte and block counting
  // ****************************************************************
  ccs_xfer_e         xs_r;
  ccs_xfer_e         xs_nxt;
  logic [BLEN_W-1:0] bcnt_r;
  logic [BLEN_W-1:0] bcnt_nxt;
  logic [NBLK_W-1:0] remain_r;
  logic [NBLK_W-1:0] remain_nxt;
  logic              byte_evt;
  logic              block_end;
  logic              xfer_done_evt;
  logic              data_done_evt;

  assign byte_evt = xfer_dir_write ? evt.tx_byte_load : evt.rd_byte_recv;

  always_comb
  begin
    xs_nxt        = xs_r;
    bcnt_nxt      = bcnt_r;
    remain_nxt    = remain_r;
    xfer_done_evt = 1'b0;
    data_done_evt = 1'b0;
    block_end     = (bcnt_r == blen_r - 1'b1);
    case (xs_r)
      XS_IDLE:
      begin
        if (start)
        begin
          xs_nxt     = XS_MOVE;
          bcnt_nxt   = '0;
          remain_nxt = nblk_r;
        end
      end
      XS_MOVE:
      begin
        if (byte_evt)
        begin
          bcnt_nxt = block_end ? '0 : bcnt_r + 1'b1;
          if (block_end && remain_r != '0)
          begin
            remain_nxt = remain_r - 1'b1;
            if (remain_r == 16'h0001)
            begin
              xfer_done_evt = 1'b1;
              xs_nxt        = XS_FINISH;
            end
          end
        end
      end
      XS_FINISH:
      begin
        // done only after crc and card programming end
        if (xfer_dir_write ? evt.wr_block_finished : evt.rd_block_crc_ok)
        begin
          data_done_evt = 1'b1;
          xs_nxt        = XS_IDLE;
        end
      end
      default:
      begin
        xs_nxt = XS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xs_r     <= XS_IDLE;
      bcnt_r   <= '0;
      remain_r <= '0;
    end
    else
    begin
      xs_r     <= xs_nxt;
      bcnt_r   <= bcnt_nxt;
      remain_r <= remain_nxt;
    end
  end

  // ****************************************************************
  // fifo thresholds, dma events, pin edges, clock stop, busy wait
  // ****************************************************************
  logic [LVL_W-1:0] thresh;
  logic             rx_above;
  logic             tx_below;
  logic             rx_above_r;
  logic             tx_below_r;
  logic             rx_chunk;
  logic             tx_chunk;
  logic             dat3_d_r;
  logic             clk_d_r;
  logic [7:0]       quiet_r;
  logic [7:0]       quiet_nxt;
  logic             busy_pend_r;
  logic             busy_pend_nxt;
  logic             busy_done_evt;
  logic             moving;

  assign thresh   = fctl_r[FLD_FIFO_LEVEL_SEL] ? THRESH_LARGE : THRESH_SMALL;
  assign moving   = (xs_r == XS_MOVE);
  assign rx_above = moving & ~xfer_dir_write & (fifo_level > thresh);
  assign tx_below = moving & xfer_dir_write & (fifo_level < thresh);
  assign rx_chunk = rx_above & ~rx_above_r;
  assign tx_chunk = tx_below & ~tx_below_r;

  always_comb
  begin
    quiet_nxt = quiet_r;
    if (clk_pin_s != clk_d_r)
    begin
      quiet_nxt = '0;
    end
    else if (quiet_r < 8'(CLK_STOP_CYCLES))
    begin
      quiet_nxt = quiet_r + 8'h01;
    end
    busy_pend_nxt = busy_pend_r;
    busy_done_evt = 1'b0;
    if (!busy_expected)
    begin
      busy_pend_nxt = 1'b1;
    end
    else if (busy_pend_r && !card_busy)
    begin
      busy_done_evt = 1'b1;
      busy_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_above_r  <= 1'b0;
      tx_below_r  <= 1'b0;
      dat3_d_r    <= 1'b0;
      clk_d_r     <= 1'b0;
      quiet_r     <= '0;
      busy_pend_r <= 1'b1;
      dma_rx_req  <= 1'b0;
      dma_tx_req  <= 1'b0;
    end
    else
    begin
      rx_above_r  <= rx_above;
      tx_below_r  <= tx_below;
      dat3_d_r    <= dat3_pin_s;
      clk_d_r     <= clk_pin_s;
      quiet_r     <= quiet_nxt;
      busy_pend_r <= busy_pend_nxt;
      dma_rx_req  <= rx_chunk;
      dma_tx_req  <= tx_chunk;
    end
  end

  // ****************************************************************
  // primary status flags, read clear, interrupt
  // ****************************************************************
  ccs_flags_s flags_r;
  ccs_flags_s flags_nxt;
  ccs_flags_s set_v;
  logic       st_read;
  logic       rx_read;
  logic       tx_write;

  assign st_read  = rd_take & (wb_adr_i == OFS_PRIMARY_STATUS);
  assign rx_read  = rd_take & (wb_adr_i == OFS_RX_DATA);
  assign tx_write = wr_take & (wb_adr_i == OFS_TX_DATA);

  always_comb
  begin
    set_v                    = '0;
    set_v.data_done          = data_done_evt;
    set_v.transfer_done      = xfer_done_evt;
    set_v.busy_done          = busy_done_evt;
    set_v.response_done      = (evt.resp_received & ~evt.resp_crc_err)
                             | (evt.cmd_sent & ~evt.resp_expected);
    set_v.response_crc_error = evt.resp_crc_err;
    set_v.read_crc_error     = evt.rd_crc_err;
    set_v.write_crc_error    = evt.wr_crc_err;
    set_v.response_timeout   = evt.resp_timeout;
    set_v.read_data_timeout  = evt.rd_timeout;
    set_v.dat3_edge          = dat3_pin_s ^ dat3_d_r;
    set_v.rx_ready           = rx_chunk;
    set_v.tx_ready           = tx_chunk;
    flags_nxt                = flags_r;
    if (st_read)
    begin
      flags_nxt = '0;
    end
    if (rx_read)
    begin
      flags_nxt.rx_ready = 1'b0;
    end
    if (tx_write)
    begin
      flags_nxt.tx_ready = 1'b0;
    end
    flags_nxt = flags_nxt | set_v;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags_r <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      irq     <= |(flags_nxt & mask_r);
    end
  end

  // ****************************************************************
  // read mux and data register strobes
  // ****************************************************************
  logic [31:0] sec_stat;

  always_comb
  begin
    sec_stat                     = '0;
    sec_stat[FLD_TX_SHIFT_EMPTY] = tx_shift_empty;
    sec_stat[FLD_RX_SHIFT_FULL]  = rx_shift_full;
    sec_stat[FLD_CLOCK_STOPPED]  = (quiet_r == 8'(CLK_STOP_CYCLES));
    sec_stat[FLD_XFER_ACTIVE]    = (xs_r != XS_IDLE);
    sec_stat[FLD_CARD_BUSY]      = card_busy;
    ack_nxt  = take;
    rdat_nxt = '0;
    if (rd_take)
    begin
      case (wb_adr_i)
        OFS_PRIMARY_STATUS: rdat_nxt = {{(32-NUM_FLAGS){1'b0}}, flags_r};
        OFS_SECONDARY_STAT: rdat_nxt = sec_stat;
        OFS_IRQ_MASK:       rdat_nxt = {{(32-NUM_FLAGS){1'b0}}, mask_r};
        OFS_BLOCK_LENGTH:   rdat_nxt = {{(32-BLEN_W){1'b0}}, blen_r};
        OFS_BLOCK_COUNT:    rdat_nxt = {{(32-NBLK_W){1'b0}}, nblk_r};
        OFS_BLOCKS_REMAIN:  rdat_nxt = {{(32-NBLK_W){1'b0}}, remain_r};
        OFS_FIFO_CONTROL:   rdat_nxt = {30'h0, fctl_r};
        OFS_RX_DATA:        rdat_nxt = rx_fifo_data;
        default:            rdat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_r        <= 1'b0;
      rdat_r       <= '0;
      tx_fifo_push <= 1'b0;
      tx_fifo_data <= '0;
      rx_fifo_pop  <= 1'b0;
    end
    else
    begin
      ack_r        <= ack_nxt;
      rdat_r       <= rdat_nxt;
      tx_fifo_push <= tx_write;
      tx_fifo_data <= tx_write ? wb_dat_i : tx_fifo_data;
      rx_fifo_pop  <= rx_read;
    end
  end

  // free running: no halt input exists, so emulation halts change nothing
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

endmodule : ccs_status_irq
`default_nettype wire

// ### test/ccs_status_irq_checker.sv
// checker: bus, interrupt and dma relations at the block ports
`timescale 1ns/100ps
`default_nettype none
module ccs_status_irq_checker
  import ccs_pkg::*;
(
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire ccs_evt_s         evt,
  input wire logic [LVL_W-1:0] fifo_level,
  input wire logic [31:0]      rx_fifo_data,
  input wire logic             irq,
  input wire logic             dma_rx_req,
  input wire logic             tx_fifo_push,
  input wire logic [31:0]      tx_fifo_data,
  input wire logic             rx_fifo_pop
);
  // ********************************
  // mask shadow and relations
  // ********************************
  logic        take;
  logic [12:0] mask_sh;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
      mask_sh <= '0;
    else if (take && wb_we_i && wb_adr_i == OFS_IRQ_MASK && wb_sel_i == 4'hF)
      mask_sh <= wb_dat_i[12:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_ack_pulse:
    assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not one pulse after a request");
  chk_mask_gate:
    assert property (mask_sh == '0 && $past(mask_sh) == '0 |-> !irq)
    else $error("irq high with every enable off");
  chk_irq_hold:
    assert property (irq && !take |=> irq)
    else $error("irq dropped without any access");
  chk_read_clear:
    assert property (take && !wb_we_i && wb_adr_i == OFS_PRIMARY_STATUS && evt == '0 |=> !irq)
    else $error("status read left irq high");
  chk_dma_rx_level:
    assert property (dma_rx_req |-> !$past(dma_rx_req) && $past(fifo_level) > THRESH_SMALL)
    else $error("rx dma request without fill above threshold");
  chk_crc_irq:
    assert property (evt.rd_crc_err && mask_sh[6] |=> irq)
    else $error("read crc error gave no irq");
  chk_tmo_irq:
    assert property (evt.resp_timeout && mask_sh[4] |=> irq)
    else $error("response timeout gave no irq");
  chk_tx_push:
    assert property (take && wb_we_i && wb_adr_i == OFS_TX_DATA
                     |=> tx_fifo_push && tx_fifo_data == $past(wb_dat_i))
    else $error("tx data write not pushed");
  chk_rx_pop:
    assert property (take && !wb_we_i && wb_adr_i == OFS_RX_DATA
                     |=> rx_fifo_pop && wb_dat_o == $past(rx_fifo_data))
    else $error("rx data read not popped");
endmodule : ccs_status_irq_checker
bind ccs_status_irq ccs_status_irq_checker ccs_status_irq_checker_i (
  .mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt(evt), .fifo_level(fifo_level),
  .rx_fifo_data(rx_fifo_data), .irq(irq), .dma_rx_req(dma_rx_req),
  .tx_fifo_push(tx_fifo_push), .tx_fifo_data(tx_fifo_data), .rx_fifo_pop(rx_fifo_pop)
);
`default_nettype wire

// ### test/ccs_host_model.sv
// model of the dma controller that serves the block's requests
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       dma_rx_req,
  input  wire logic       dma_tx_req,
  output logic      [7:0] rx_cnt,
  output logic      [7:0] tx_cnt
);
  // one chunk served per request pulse
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b)
    begin
      rx_cnt <= 8'h00;
      tx_cnt <= 8'h00;
    end
    else
    begin
      rx_cnt <= rx_cnt + 8'(dma_rx_req);
      tx_cnt <= tx_cnt + 8'(dma_tx_req);
    end
endmodule : ccs_host_model
`default_nettype wire

// ### test/ccs_status_irq_bench.sv
// bench: register, event, transfer, fifo and pin scenarios
`timescale 1ns/100ps
`default_nettype none
module ccs_status_irq_bench
  import ccs_pkg::*;
;
  logic mclk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, fifo_level = 8'h20, rx_cnt, tx_cnt;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rx_fifo_data = 32'h0, wb_dat_o, tx_fifo_data, q;
  ccs_evt_s evt = '0;
  logic busy_expected = 1'h0, card_busy = 1'h0, tx_shift_empty = 1'h0, rx_shift_full = 1'h0;
  logic card_clock_pin = 1'h0, card_data3_pin = 1'h0, lk_run = 1'h0;
  logic wb_ack_o, irq, dma_rx_req, dma_tx_req, tx_fifo_push, rx_fifo_pop, xfer_dir_write;
  int failures = 0, n_compared = 0, cycles = 0;
  ccs_status_irq ccs_status_irq_i (
    .mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .evt, .busy_expected, .card_busy, .tx_shift_empty,
    .rx_shift_full, .fifo_level, .rx_fifo_data, .card_clock_pin, .card_data3_pin,
    .irq, .dma_rx_req, .dma_tx_req, .tx_fifo_push, .tx_fifo_data, .rx_fifo_pop,
    .xfer_dir_write
  );
  ccs_host_model ccs_host_model_i (.mclk, .rst_b, .dma_rx_req, .dma_tx_req, .rx_cnt, .tx_cnt);
  // ********************************
  // clocks, watchdog, helpers
  // ********************************
  always #2.5 mclk = ~mclk;
  always #32 if (lk_run) card_clock_pin = ~card_clock_pin;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    // wait for ack however long it takes; only the watchdog ends a hang
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge mclk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    check(q, exp);
  endtask : rd
  task automatic pulse(input logic [11:0] v);
    evt <= ccs_evt_s'(v);
    @(posedge mclk);
    evt <= '0;
    repeat (2) @(posedge mclk);
  endtask : pulse
  task automatic do_reset;
    rst_b <= 1'h0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
  endtask : do_reset
  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs;
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_BLOCK_LENGTH, 32'h200);
    rd(OFS_BLOCK_COUNT, 32'h0);
    rd(OFS_FIFO_CONTROL, 32'h0);
    bus(1'h1, 8'h3C, 32'hFFFF);
    rd(8'h3C, 32'h0);
    bus(1'h1, OFS_BLOCKS_REMAIN, 32'h5);
    rd(OFS_BLOCKS_REMAIN, 32'h0);
  endtask : t_regs
  task automatic t_events;
    logic [11:0] ev [9] = '{12'h100, 12'h020, 12'h010, 12'h080, 12'h040,
                            12'h800, 12'h200, 12'h300, 12'hC00};
    logic [31:0] ex [9] = '{32'h80, 32'h40, 32'h20, 32'h10, 32'h08,
                            32'h04, 32'h04, 32'h80, 32'h0};
    bus(1'h1, OFS_IRQ_MASK, 32'h1FFF);
    for (int i = 0; i < 9; i++)
    begin
      pulse(ev[i]);
      check(irq, |ex[i]);
      rd(OFS_PRIMARY_STATUS, ex[i]);
      check(irq, 32'h0);
    end
    rd(OFS_PRIMARY_STATUS, 32'h0);
    bus(1'h1, OFS_IRQ_MASK, 32'h10);
    pulse(12'h040);
    check(irq, 32'h0);
    pulse(12'h080);
    repeat (8) @(posedge mclk);
    check(irq, 32'h1);
    rd(OFS_PRIMARY_STATUS, 32'h18);
    {busy_expected, card_busy} <= 2'h3;
    repeat (4) @(posedge mclk);
    rd(OFS_SECONDARY_STAT, 32'h14);
    rd(OFS_PRIMARY_STATUS, 32'h0);
    card_busy <= 1'h0;
    repeat (4) @(posedge mclk);
    busy_expected <= 1'h0;
    rd(OFS_PRIMARY_STATUS, 32'h2);
  endtask : t_events
  task automatic t_xfer(input logic d);
    bus(1'h1, OFS_BLOCK_LENGTH, 32'h4);
    bus(1'h1, OFS_BLOCK_COUNT, 32'h2);
    bus(1'h1, OFS_FIFO_CONTROL, {30'h0, d, 1'h0});
    bus(1'h1, OFS_XFER_CONTROL, 32'h1);
    check(xfer_dir_write, d);
    for (int i = 1; i <= 8; i++)
    begin
      pulse(d ? 12'h002 : 12'h008);
      if (i == 4)
        rd(OFS_BLOCKS_REMAIN, 32'h1);
      if (i == 4)
        rd(OFS_SECONDARY_STAT, 32'hC);
      if (i == 7)
        rd(OFS_PRIMARY_STATUS, 32'h0);
    end
    // software would answer with a stop command here
    rd(OFS_PRIMARY_STATUS, 32'h1000);
    pulse(d ? 12'h001 : 12'h004);
    rd(OFS_PRIMARY_STATUS, 32'h1);
  endtask : t_xfer
  task automatic t_rx;
    do_reset();
    bus(1'h1, OFS_FIFO_CONTROL, 32'h1);
    bus(1'h1, OFS_IRQ_MASK, 32'h400);
    bus(1'h1, OFS_XFER_CONTROL, 32'h1);
    fifo_level <= 8'h30;
    repeat (4) @(posedge mclk);
    check(irq, 32'h0);
    fifo_level <= 8'h41;
    repeat (4) @(posedge mclk);
    check(irq, 32'h1);
    check(rx_cnt, 8'h1);
    rx_fifo_data <= 32'hA5C30F12;
    rd(OFS_RX_DATA, 32'hA5C30F12);
    check(irq, 32'h0);
    fifo_level <= 8'h20;
    repeat (4) @(posedge mclk);
    fifo_level <= 8'h50;
    repeat (4) @(posedge mclk);
    check(irq, 32'h1);
    check(rx_cnt, 8'h2);
  endtask : t_rx
  task automatic t_tx;
    do_reset();
    fifo_level <= 8'h40;
    bus(1'h1, OFS_FIFO_CONTROL, 32'h2);
    bus(1'h1, OFS_IRQ_MASK, 32'h200);
    bus(1'h1, OFS_XFER_CONTROL, 32'h1);
    fifo_level <= 8'h1F;
    repeat (4) @(posedge mclk);
    check(irq, 32'h1);
    check(tx_cnt, 8'h1);
    bus(1'h1, OFS_TX_DATA, 32'h5AF033CC);
    check(irq, 32'h0);
  endtask : t_tx
  task automatic t_pins;
    do_reset();
    bus(1'h1, OFS_IRQ_MASK, 32'h1FFF);
    {tx_shift_empty, rx_shift_full, lk_run} <= 3'h7;
    repeat (20) @(posedge mclk);
    check(irq, 32'h0);
    rd(OFS_SECONDARY_STAT, 32'h3);
    lk_run <= 1'h0;
    repeat (40) @(posedge mclk);
    rd(OFS_SECONDARY_STAT, 32'h7);
    for (int i = 0; i < 2; i++)
    begin
      card_data3_pin <= ~card_data3_pin;
      repeat (6) @(posedge mclk);
      check(irq, 32'h1);
      rd(OFS_PRIMARY_STATUS, 32'h800);
    end
  endtask : t_pins
  // scenarios run back to back, nothing pauses the block
  initial
  begin
    do_reset();
    t_regs();
    t_events();
    t_xfer(1'h1);
    t_xfer(1'h0);
    t_rx();
    t_tx();
    t_pins();
    complete_run();
  end
endmodule : ccs_status_irq_bench
`default_nettype wire
